// ### hdl/machine_safety_interlock.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module machine_safety_interlock
  import interlock_pkg::*;
#(
  parameter int POS_W = 24,
  parameter int DEB_CYCLES = interlock_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Machine pins
  input wire interlock_pkg::pins_s pins,
  // Motion status from the controller
  input wire logic [2:0] moving_pos,
  input wire logic [2:0] moving_neg,
  input wire logic [2:0] jog_pos_req,
  input wire logic [2:0] jog_neg_req,
  input wire logic auto_start_req,
  input wire logic action_busy,
  input wire logic tool_change_busy,
  input wire logic pressure_low_in,
  input wire logic delay_interface_in,
  input wire interlock_pkg::aux_s aux_req,
  // Motion control outputs
  output logic [2:0] allow_pos,
  output logic [2:0] allow_neg,
  output logic [2:0] decel_axis,
  output logic feed_stop,
  output logic program_abort,
  output logic auto_start_grant,
  output logic action_abort,
  output logic custom_run,
  output logic red_flash,
  output logic dry_run_exit,
  output logic rapid_to_feed,
  output logic interval_restart,
  output logic delay_interface_out,
  output interlock_pkg::aux_s aux_out,
  output logic [2:0] drive_alarm
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam int NB = 12;
  localparam int DW = $clog2(DEB_CYCLES + 1);

  if (POS_W < 2 || POS_W > 32 || DEB_CYCLES < 1) begin
    $error("machine_safety_interlock: unsupported parameters");
  end

  logic [31:0] config_reg;
  logic [POS_W-1:0] bound [NB];
  logic [POS_W-1:0] pos [6];
  op_mode_e mode, saved_mode;
  logic [5:0] sync1, sync2, stable;
  logic [DW-1:0] deb_cnt [6];
  logic halt_alarm, halt_prev, chuck_closed, tail_advanced, foot_armed, press_alarm;
  logic reset_cmd, foot_cmd, redo_cmd, mech_alarm, tool_alarm;
  logic [2:0] over_pos, over_neg, drv_active;
  logic limit_pos_alarm, limit_neg_alarm, halt_active, any_drive, apb_wr, apb_rd;

  function automatic logic beyond_hi(input logic [POS_W-1:0] p, input logic [POS_W-1:0] b);
    beyond_hi = $signed(p) > $signed(b);
  endfunction

  function automatic logic beyond_lo(input logic [POS_W-1:0] p, input logic [POS_W-1:0] b);
    beyond_lo = $signed(p) < $signed(b);
  endfunction

  assign apb_wr = psel && penable && pwrite && clk_en;
  assign apb_rd = psel && !penable && !pwrite && clk_en;

  // ----------------------------------------
  // Input synchronisation and debounce
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else if (clk_en) begin
      sync1 <= {pins.positive_limit, pins.negative_limit, pins.halt, pins.drive};
      sync2 <= sync1;
    end
  end

  // A change is accepted only after it holds for the whole debounce span.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable <= 6'h00;
      deb_cnt <= '{default: '0};
    end else if (clk_en) begin
      for (int i = 0; i < 6; i++) begin
        if (sync2[i] == stable[i]) begin
          deb_cnt[i] <= '0;
        end else if (deb_cnt[i] == DW'(DEB_CYCLES - 1)) begin
          stable[i] <= sync2[i];
          deb_cnt[i] <= '0;
        end else begin
          deb_cnt[i] <= deb_cnt[i] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Alarm decoding
  // ----------------------------------------
  always_comb begin
    // Normally closed chain alarms high when opened; open chain alarms low when closed.
    limit_pos_alarm = config_reg[CFG_LIMIT_POL] ? stable[5] : !stable[5];
    limit_neg_alarm = config_reg[CFG_LIMIT_POL] ? stable[4] : !stable[4];
    // The halt button is normally closed, so a low level means pressed.
    halt_active = !stable[3] && !config_reg[CFG_HALT_DIS];
    drv_active[2] = (stable[2] == config_reg[CFG_Z_LVL]);
    drv_active[1] = (stable[1] == config_reg[CFG_X_LVL]);
    drv_active[0] = (stable[0] == config_reg[CFG_Y_LVL]);
    if (config_reg[CFG_DRV_CHECK]) begin
      drv_active = 3'b000;
    end
    any_drive = |drv_active;
    for (int a = 0; a < 3; a++) begin
      over_pos[a] = (config_reg[CFG_MECH_EN] && beyond_hi(pos[a], bound[2*a])) ||
                    (config_reg[CFG_TOOL_EN] && beyond_hi(pos[a+3], bound[2*a+6]));
      over_neg[a] = (config_reg[CFG_MECH_EN] && beyond_lo(pos[a], bound[2*a+1])) ||
                    (config_reg[CFG_TOOL_EN] && beyond_lo(pos[a+3], bound[2*a+7]));
    end
    mech_alarm = 1'b0;
    tool_alarm = 1'b0;
    for (int a = 0; a < 3; a++) begin
      mech_alarm = mech_alarm || (config_reg[CFG_MECH_EN] &&
                   (beyond_hi(pos[a], bound[2*a]) || beyond_lo(pos[a], bound[2*a+1])));
      tool_alarm = tool_alarm || (config_reg[CFG_TOOL_EN] &&
                   (beyond_hi(pos[a+3], bound[2*a+6]) ||
                    beyond_lo(pos[a+3], bound[2*a+7])));
    end
  end

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= CONFIG_RESET;
      bound <= '{default: '0};
      pos <= '{default: '0};
    end else if (apb_wr) begin
      if (paddr == ADDR_CONFIG) begin
        config_reg <= {20'h00000, pwdata[11:0]};
      end
      for (int i = 0; i < NB; i++) begin
        if (paddr == ADDR_BOUND_BASE + 8'(4 * i)) begin
          bound[i] <= pwdata[POS_W-1:0];
        end
      end
      for (int i = 0; i < 6; i++) begin
        if (paddr == ADDR_POS_BASE + 8'(4 * i)) begin
          pos[i] <= pwdata[POS_W-1:0];
        end
      end
    end
  end

  // Command pulses last one cycle after the write completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_cmd <= 1'b0;
      foot_cmd <= 1'b0;
      redo_cmd <= 1'b0;
    end else if (clk_en) begin
      reset_cmd <= apb_wr && paddr == ADDR_COMMAND && pwdata[CMD_RESET];
      foot_cmd <= apb_wr && paddr == ADDR_COMMAND && pwdata[CMD_FOOT];
      redo_cmd <= apb_wr && paddr == ADDR_COMMAND && pwdata[CMD_REDO];
    end
  end

  // Reads are captured in setup so the access phase answers with zero wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_rd) begin
        prdata <= 32'h00000000;
        if (paddr == ADDR_CONFIG) begin
          prdata <= config_reg;
        end else if (paddr == ADDR_STATUS) begin
          prdata <= {20'h00000, press_alarm, red_flash, tail_advanced, chuck_closed,
                     drv_active, tool_alarm, mech_alarm, limit_neg_alarm,
                     limit_pos_alarm, halt_alarm};
        end else if (paddr == ADDR_MODE) begin
          prdata <= {29'h0, mode};
        end else if (paddr >= ADDR_BOUND_BASE && paddr < ADDR_POS_BASE + 8'h18) begin
          for (int i = 0; i < NB; i++) begin
            if (paddr == ADDR_BOUND_BASE + 8'(4 * i)) begin
              prdata <= 32'(bound[i]);
            end
          end
          for (int i = 0; i < 6; i++) begin
            if (paddr == ADDR_POS_BASE + 8'(4 * i)) begin
              prdata <= 32'(pos[i]);
            end
          end
        end else if (paddr != ADDR_COMMAND) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Halt alarm and operating mode
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_alarm <= 1'b0;
      halt_prev <= 1'b0;
      mode <= MODE_EDIT;
      saved_mode <= MODE_EDIT;
    end else if (clk_en) begin
      halt_prev <= halt_active;
      if (halt_active && !halt_alarm) begin
        halt_alarm <= 1'b1;
        saved_mode <= mode;
      end else if (reset_cmd && halt_alarm && !halt_active) begin
        halt_alarm <= 1'b0;
        mode <= saved_mode;
      end
      if (apb_wr && paddr == ADDR_MODE) begin
        // Mode requests that the active halt forbids are simply not taken.
        if (!(halt_active && (op_mode_e'(pwdata[2:0]) == MODE_MANUAL ||
            op_mode_e'(pwdata[2:0]) == MODE_AUTO ||
            op_mode_e'(pwdata[2:0]) == MODE_DIAG)) && pwdata[2:0] <= 3'h5) begin
          mode <= op_mode_e'(pwdata[2:0]);
        end
      end
    end
  end

  // ----------------------------------------
  // Chuck, tailstock and action recovery
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chuck_closed <= 1'b0;
      tail_advanced <= 1'b0;
      foot_armed <= 1'b0;
      red_flash <= 1'b0;
    end else if (clk_en) begin
      if (halt_alarm) begin
        chuck_closed <= 1'b0;
        tail_advanced <= 1'b0;
        foot_armed <= 1'b1;
      end else if (foot_cmd && foot_armed) begin
        chuck_closed <= 1'b1;
        tail_advanced <= 1'b1;
        foot_armed <= 1'b0;
      end
      if (halt_active && action_busy) begin
        red_flash <= 1'b1;
      end else if (redo_cmd && !halt_alarm) begin
        red_flash <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pressure alarm
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press_alarm <= 1'b0;
    end else if (clk_en) begin
      if (pressure_low_in) begin
        press_alarm <= 1'b1;
      end else if (reset_cmd) begin
        press_alarm <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Motion gating
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      allow_pos <= 3'b000;
      allow_neg <= 3'b000;
      decel_axis <= 3'b000;
      feed_stop <= 1'b1;
      program_abort <= 1'b0;
      auto_start_grant <= 1'b0;
      drive_alarm <= 3'b000;
    end else if (clk_en) begin
      for (int a = 0; a < 3; a++) begin
        // Leaving the limit stays allowed so the operator can jog back.
        allow_pos[a] <= jog_pos_req[a] && !limit_pos_alarm && !over_pos[a] &&
                        !any_drive && !halt_active;
        allow_neg[a] <= jog_neg_req[a] && !limit_neg_alarm && !over_neg[a] &&
                        !any_drive && !halt_active;
        decel_axis[a] <= (over_pos[a] && moving_pos[a]) || (over_neg[a] && moving_neg[a]) ||
                         (reset_cmd && (moving_pos[a] || moving_neg[a]));
      end
      feed_stop <= halt_active || any_drive || limit_pos_alarm || limit_neg_alarm;
      program_abort <= halt_active || any_drive || reset_cmd;
      auto_start_grant <= auto_start_req && mode == MODE_AUTO && !any_drive &&
                          !halt_alarm;
      drive_alarm <= drv_active;
    end
  end

  // ----------------------------------------
  // Auxiliary outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_out <= '0;
      delay_interface_out <= 1'b0;
      action_abort <= 1'b0;
      custom_run <= 1'b0;
      dry_run_exit <= 1'b0;
      rapid_to_feed <= 1'b0;
      interval_restart <= 1'b0;
    end else if (clk_en) begin
      delay_interface_out <= delay_interface_in;
      aux_out <= aux_req;
      if (halt_alarm) begin
        aux_out.spindle <= 1'b0;
        aux_out.coolant <= 1'b0;
        aux_out.lube <= 1'b0;
        if (config_reg[CFG_OUT_SHUT]) begin
          aux_out.chuck <= 1'b0;
          aux_out.tailstock <= 1'b0;
          aux_out.other_aux <= 1'b0;
        end
      end else if (reset_cmd && !config_reg[CFG_RST_KEEP]) begin
        aux_out.spindle <= 1'b0;
        aux_out.coolant <= 1'b0;
        aux_out.lube <= 1'b0;
      end
      action_abort <= halt_active && action_busy;
      // The routine starts only while the halt alarm is latched and nothing moves.
      custom_run <= halt_alarm && config_reg[CFG_CUSTOM] && config_reg[CFG_M74_PRESENT] &&
                    (saved_mode == MODE_MANUAL || saved_mode == MODE_AUTO) &&
                    !any_drive && !limit_pos_alarm && !limit_neg_alarm &&
                    !(|moving_pos) && !(|moving_neg) && !tool_change_busy;
      dry_run_exit <= !halt_active && halt_prev && saved_mode == MODE_AUTO;
      rapid_to_feed <= !halt_active && halt_prev && saved_mode == MODE_MANUAL;
      interval_restart <= (!halt_active && halt_prev) || (reset_cmd && press_alarm);
    end
  end

endmodule

// ### common/interlock_pkg.sv
package interlock_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COMMAND = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_BOUND_BASE = 8'h10;
  localparam logic [7:0] ADDR_POS_BASE = 8'h40;
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;

  // ----------------------------------------
  // Config bit positions
  // ----------------------------------------
  localparam int CFG_LIMIT_POL = 0;
  localparam int CFG_MECH_EN = 1;
  localparam int CFG_TOOL_EN = 2;
  localparam int CFG_HALT_DIS = 3;
  localparam int CFG_OUT_SHUT = 4;
  localparam int CFG_RST_KEEP = 5;
  localparam int CFG_CUSTOM = 6;
  localparam int CFG_DRV_CHECK = 7;
  localparam int CFG_Z_LVL = 8;
  localparam int CFG_X_LVL = 9;
  localparam int CFG_Y_LVL = 10;
  localparam int CFG_M74_PRESENT = 11;

  // ----------------------------------------
  // Command bits (write one to act)
  // ----------------------------------------
  localparam int CMD_RESET = 0;
  localparam int CMD_FOOT = 1;
  localparam int CMD_REDO = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DEBOUNCE_US = 4;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

  typedef enum logic [2:0] {
    MODE_EDIT, MODE_PARAM, MODE_OFFSET, MODE_MANUAL, MODE_AUTO, MODE_DIAG
  } op_mode_e;

  typedef struct packed {
    logic positive_limit;
    logic negative_limit;
    logic halt;
    logic [2:0] drive;
  } pins_s;

  typedef struct packed {
    logic spindle;
    logic coolant;
    logic lube;
    logic chuck;
    logic tailstock;
    logic other_aux;
  } aux_s;

endpackage

// ### verif/interlock_chk.sv
`timescale 1ns/100ps
module interlock_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Machine side
  input wire interlock_pkg::aux_s aux_req,
  input wire interlock_pkg::aux_s aux_out,
  input wire logic [2:0] drive_alarm,
  input wire logic [2:0] allow_pos,
  input wire logic [2:0] allow_neg,
  input wire logic feed_stop,
  input wire logic auto_start_grant,
  input wire logic red_flash,
  input wire logic dry_run_exit,
  input wire logic rapid_to_feed,
  input wire logic interval_restart
);
  import interlock_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  chk_ready_access: assert property (psel && !penable |=> pready && penable)
    else $error("ready missing in access cycle");
  chk_err_scope: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access cycle");
  chk_unmapped_read: assert property (rd_acc && paddr >= 8'h58 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  // ----------------------------------------
  // Machine outputs
  // ----------------------------------------
  // Status is captured one edge before the access cycle, so the flags must have stood still.
  chk_status_drive: assert property (
    rd_acc && paddr == ADDR_STATUS && $stable(drive_alarm) && drive_alarm == $past(drive_alarm, 2)
    |-> prdata[7:5] == drive_alarm) else $error("status drive bits differ");
  chk_status_flash: assert property (
    rd_acc && paddr == ADDR_STATUS && $stable(red_flash) && red_flash == $past(red_flash, 2)
    |-> prdata[10] == red_flash) else $error("status flash bit differs");
  chk_drive_feed: assert property (drive_alarm != 3'h0 |-> feed_stop)
    else $error("feed runs during drive alarm");
  chk_drive_block: assert property (
    (drive_alarm != 3'h0) [*2] |-> allow_pos == 3'h0 && allow_neg == 3'h0 && !auto_start_grant)
    else $error("motion allowed during drive alarm");
  chk_spindle_req: assert property (aux_out.spindle |-> $past(aux_req.spindle))
    else $error("spindle on without request");
  chk_lube_req: assert property (aux_out.lube |-> $past(aux_req.lube))
    else $error("lubrication on without request");
  chk_pulse_once: assert property (dry_run_exit |=> !dry_run_exit)
    else $error("dry run exit longer than one cycle");
  chk_restart_pair: assert property (dry_run_exit || rapid_to_feed |-> interval_restart)
    else $error("interval restart missing on release");
  cover property (rd_acc && pslverr);
  cover property (drive_alarm != 3'h0);
  cover property (red_flash);
  cover property (interval_restart);
endmodule

// ### verif/machine_pins_model.sv
`timescale 1ns/100ps
module machine_pins_model #(
  parameter int BOUNCE = 3
) (
  // Clock
  input wire logic pclk,
  // Switch states set by the bench
  input wire logic limit_nc,
  input wire logic pos_hit,
  input wire logic neg_hit,
  input wire logic halt_pressed,
  input wire logic [2:0] drive_fault,
  input wire logic [2:0] drive_lvl,
  // Wires into the block
  output interlock_pkg::pins_s pins
);
  import interlock_pkg::*;
  pins_s target;
  pins_s diff;
  int bounce;
  // ----------------------------------------
  // Contact wiring
  // ----------------------------------------
  // An opened closed chain reads high, a made open chain reads low.
  always_comb begin
    target.positive_limit = limit_nc ? pos_hit : !pos_hit;
    target.negative_limit = limit_nc ? neg_hit : !neg_hit;
    target.halt = !halt_pressed;
    target.drive = ~(drive_fault ^ drive_lvl);
  end
  // ----------------------------------------
  // Contact bounce
  // ----------------------------------------
  // Every edge chatters for a few cycles so the input filter is really exercised.
  always_ff @(posedge pclk) begin
    if (bounce == 0) begin
      if (target !== pins) begin
        diff <= target ^ pins;
        pins <= target;
        bounce <= BOUNCE;
      end
    end else begin
      bounce <= bounce - 1;
      pins <= (bounce == 1) ? target : pins ^ diff;
    end
  end
endmodule

// ### verif/machine_safety_interlock_test.sv
`timescale 1ns/100ps
bind machine_safety_interlock interlock_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .aux_req, .aux_out, .drive_alarm, .allow_pos,
  .allow_neg, .feed_stop, .auto_start_grant, .red_flash, .dry_run_exit, .rapid_to_feed,
  .interval_restart);
module machine_safety_interlock_test;
  import interlock_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, ba, pa;
  logic [31:0] pwdata, prdata, rd, cfg, m;
  pins_s pins;
  aux_s aux_req, aux_out;
  logic [2:0] moving_pos, moving_neg, jog, drive_fault, drive_lvl;
  logic [2:0] allow_pos, allow_neg, decel_axis, drive_alarm;
  logic auto_start_req, action_busy, delay_interface_in, feed_stop, auto_start_grant;
  logic red_flash, dry_run_exit, rapid_to_feed, interval_restart, delay_interface_out;
  logic program_abort, action_abort, custom_run, tcb, plow;
  logic limit_nc, pos_hit, neg_hit, halt_pressed;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  machine_safety_interlock #(.DEB_CYCLES(4)) dut (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins, .moving_pos, .moving_neg, .jog_pos_req(jog), .jog_neg_req(jog),
    .auto_start_req, .action_busy, .tool_change_busy(tcb), .pressure_low_in(plow),
    .delay_interface_in, .aux_req, .allow_pos, .allow_neg, .decel_axis, .feed_stop,
    .program_abort, .auto_start_grant, .action_abort, .custom_run, .red_flash,
    .dry_run_exit, .rapid_to_feed, .interval_restart, .delay_interface_out, .aux_out,
    .drive_alarm
  );
  machine_pins_model partner (
    .pclk, .limit_nc, .pos_hit, .neg_hit, .halt_pressed, .drive_fault, .drive_lvl, .pins
  );

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps a following call from raising psel in this same time step.
    @(posedge pclk);
  endtask

  // Commands act one cycle after the write and outputs one cycle later still.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (3) @(posedge pclk);
  endtask

  // Covers contact bounce, input synchroniser and filter with margin.
  task automatic settle;
    repeat (24) @(posedge pclk);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd & msk, e);
  endtask

  task automatic report_and_stop;
    $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cfg, limit_nc} = '0;
    {moving_pos, moving_neg, drive_fault, drive_lvl, aux_req} = '0;
    {auto_start_req, action_busy, delay_interface_in, pos_hit, neg_hit, halt_pressed} = '0;
    {tcb, plow} = '0;
    jog = 3'h7;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    wr(ADDR_COMMAND, 32'h1);
    cmp_reg(ADDR_CONFIG, 32'hffffffff, CONFIG_RESET);
    bus(1'b0, 8'hfc, 32'h0);
    cmp(err, 1'b1);
    cmp(rd, 32'h0);
    for (int p = 0; p < 2; p++) begin
      cfg[CFG_LIMIT_POL] = p[0];
      limit_nc <= p[0];
      wr(ADDR_CONFIG, cfg);
      cmp_reg(ADDR_CONFIG, 32'hfff, cfg);
      pos_hit <= 1'b1;
      settle;
      cmp_reg(ADDR_STATUS, 32'h6, 32'h2);
      cmp({allow_pos, allow_neg}, 6'h07);
      pos_hit <= 1'b0;
      neg_hit <= 1'b1;
      settle;
      cmp_reg(ADDR_STATUS, 32'h6, 32'h4);
      cmp({allow_pos, allow_neg}, 6'h38);
      neg_hit <= 1'b0;
      settle;
    end
    for (int k = 0; k < 2; k++) begin
      ba = ADDR_BOUND_BASE + 8'(24 * k);
      pa = ADDR_POS_BASE + 8'(12 * k);
      m = 32'h8 << k;
      wr(ba, 32'd100);
      wr(ba + 8'h4, 32'hffffff9c);
      wr(pa, 32'd101);
      cmp_reg(ADDR_STATUS, m, 32'h0);
      cfg[CFG_MECH_EN + k] = 1'b1;
      moving_pos <= 3'h1;
      wr(ADDR_CONFIG, cfg);
      cmp_reg(ADDR_STATUS, m, m);
      cmp({allow_pos[0], allow_neg[0], decel_axis[0]}, 3'b011);
      moving_pos <= 3'h0;
      moving_neg <= 3'h1;
      wr(pa, 32'hffffff9b);
      cmp_reg(ADDR_STATUS, m, m);
      cmp({allow_pos[0], allow_neg[0], decel_axis[0]}, 3'b101);
      moving_neg <= 3'h0;
      wr(pa, 32'd100);
      cmp_reg(ADDR_STATUS, m, 32'h0);
      cfg[CFG_MECH_EN + k] = 1'b0;
      wr(ADDR_CONFIG, cfg);
    end
    wr(ADDR_MODE, 32'h4);
    auto_start_req <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      drive_fault <= 3'h1 << i;
      settle;
      cmp(drive_alarm, 3'h1 << i);
      cmp({feed_stop, auto_start_grant, allow_pos, allow_neg}, 8'h80);
      cfg[CFG_Y_LVL - i] = 1'b1;
      drive_lvl[i] <= 1'b1;
      drive_fault[i] <= 1'b0;
      wr(ADDR_CONFIG, cfg);
      settle;
      cmp(drive_alarm, 3'h0);
      cmp(auto_start_grant, 1'b1);
    end
    cfg[CFG_DRV_CHECK] = 1'b1;
    drive_fault <= 3'h7;
    wr(ADDR_CONFIG, cfg);
    settle;
    cmp(drive_alarm, 3'h0);
    drive_fault <= 3'h0;
    cfg[CFG_DRV_CHECK] = 1'b0;
    cfg[CFG_CUSTOM] = 1'b1;
    cfg[CFG_M74_PRESENT] = 1'b1;
    wr(ADDR_CONFIG, cfg);
    aux_req <= '1;
    delay_interface_in <= 1'b1;
    action_busy <= 1'b1;
    settle;
    halt_pressed <= 1'b1;
    settle;
    cmp({aux_out.spindle, aux_out.coolant, aux_out.lube, aux_out.other_aux, feed_stop}, 5'h3);
    cmp({red_flash, delay_interface_out}, 2'h3);
    cmp({program_abort, action_abort, custom_run}, 3'h7);
    tcb <= 1'b1;
    repeat (2) @(posedge pclk);
    cmp(custom_run, 1'b0);
    tcb <= 1'b0;
    cmp_reg(ADDR_STATUS, 32'h301, 32'h1);
    action_busy <= 1'b0;
    cfg[CFG_OUT_SHUT] = 1'b1;
    wr(ADDR_CONFIG, cfg);
    cmp({aux_out.chuck, aux_out.tailstock, aux_out.other_aux, delay_interface_out}, 4'h1);
    wr(ADDR_MODE, 32'h3);
    cmp_reg(ADDR_MODE, 32'h7, 32'h4);
    wr(ADDR_MODE, 32'h0);
    cmp_reg(ADDR_MODE, 32'h7, 32'h0);
    halt_pressed <= 1'b0;
    settle;
    wr(ADDR_COMMAND, 32'h1);
    cmp_reg(ADDR_STATUS, 32'h1, 32'h0);
    cmp_reg(ADDR_MODE, 32'h7, 32'h4);
    wr(ADDR_COMMAND, 32'h2);
    cmp_reg(ADDR_STATUS, 32'h300, 32'h300);
    wr(ADDR_COMMAND, 32'h4);
    cmp(red_flash, 1'b0);
    cfg[CFG_OUT_SHUT] = 1'b0;
    cfg[CFG_HALT_DIS] = 1'b1;
    wr(ADDR_CONFIG, cfg);
    halt_pressed <= 1'b1;
    settle;
    cmp_reg(ADDR_STATUS, 32'h1, 32'h0);
    cmp(aux_out.spindle, 1'b1);
    plow <= 1'b1;
    @(posedge pclk);
    plow <= 1'b0;
    cmp_reg(ADDR_STATUS, 32'h800, 32'h800);
    wr(ADDR_COMMAND, 32'h1);
    cmp_reg(ADDR_STATUS, 32'h800, 32'h0);
    report_and_stop;
  end
endmodule
